// ---- power_seq.sv ----
// Default power sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`include "power_seq_map.svh"

// What this block does
// [R1] Writing 0100h to launch register 49h runs start-up from step 0
// [R2] Step 0 sets charge pump bit; step 1 writes 07h at bit 7 of 01h
// [R3] Step 2 writes 11h from bit 1 of 60h; step 3 writes 33h to 54h
// [R4] Steps 4 to 6 are dummy writes to FFh with delays 5h, 0h, 0h
// [R5] Step 7 writes 3Bh from bit 2 of 60h and ends start-up
// [R6] Writing 0110h to launch register runs shut-down from step 16
// [R7] Steps 16 to 18 clear output, servo and input-stage fields
// [R8] Step 19 clears charge pump; step 20 clears speaker bits and ends
// [R9] Each input pair clamps to mid-rail when clamp set and stage off
// [R10] Mid-rail buffer runs only while bit 3 of 39h is set, reset 0
// [R11] Clamp bits at bit 0 of 16h and 17h reset to one
// [R12] Each step lasts 62.5 us times two-to-the-code plus eight
// [R13] Width code 0..7 means 1..8 bits; other bits untouched
// [R14] Sequencer stops after a step with the end flag set
// [R15] Writes to FFh touch nothing but still take their time
module power_seq #(
  parameter int UNIT_CYC = `STEP_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analogue control levels
  output logic             charge_pump_enable,
  output logic             hp_left_input_stage_enable,
  output logic             hp_right_input_stage_enable,
  output logic             hp_left_intermediate_stage_enable,
  output logic             hp_right_intermediate_stage_enable,
  output logic             hp_left_output_stage_enable,
  output logic             hp_right_output_stage_enable,
  output logic             hp_left_short_removal,
  output logic             hp_right_short_removal,
  output logic [1:0]       servo_channel_enable,
  output logic [1:0]       servo_startup_trigger,
  output logic             speaker_output_enable,
  output logic             midrail_reference_buffer_on,
  output logic             pair1_clamp_connect,
  output logic             pair2_clamp_connect,
  output logic             seq_busy
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control registers
  logic [15:0] pair1Line_r, pair1Line_nxt;
  logic [15:0] pair2Line_r, pair2Line_nxt;
  logic [15:0] popCtrl2_r, popCtrl2_nxt;
  logic [15:0] launch_r, launch_nxt;
  logic [15:0] pwrMgmt1_r, pwrMgmt1_nxt;
  logic [15:0] servoCtl_r, servoCtl_nxt;
  logic [15:0] cpumpCtl_r, cpumpCtl_nxt;
  logic [15:0] hpAnalog_r, hpAnalog_nxt;
  // Bus handshake state
  logic        awHeld_r, awHeld_nxt;
  logic        wHeld_r, wHeld_nxt;
  logic [9:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic        bValid_r, bValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt;
  logic        rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0]  rResp_r, rResp_nxt;
  // Sequencer state
  power_seq_pkg::seq_state_t state_r, state_nxt;
  logic [4:0]  index_r, index_nxt;
  // Level outputs
  logic        busyOut_r;
  logic        midBuf_r, clamp1_r, clamp2_r;

  power_seq_pkg::step_t      curStep;
  power_seq_pkg::ctl_write_t seqWr;
  logic        timerLoad;
  logic        timerDone;
  logic        busWrite;

  step_rom u_rom (
    .index (index_r),
    .step  (curStep)
  );

  step_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (timerLoad),
    .code    (curStep.delay),
    .done    (timerDone)
  );

  // Field mask from width code and start bit
  function automatic logic [15:0] fieldMask(input logic [2:0] w,
                                            input logic [3:0] s);
    logic [15:0] base;
    base = 16'((17'h1 << (w + 3'h1 == 3'h0 ? 17'd8 : 17'(w) + 17'd1))
               - 17'h1); // see [R13]
    fieldMask = base << s;
  endfunction

  // Merge of new field bits into an old value, rest untouched
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] m,
                                        input logic [15:0] v);
    merge = (old & ~m) | (v & m); // see [R13]
  endfunction

  // Byte-lane merge of a 16-bit register from the bus
  function automatic logic [15:0] laneWrite(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] st);
    laneWrite = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  // Sequencer step write; dummy address matches no register
  always_comb begin
    seqWr.valid = (state_r == power_seq_pkg::SEQ_WRITE);
    seqWr.addr  = curStep.addr;
    seqWr.mask  = fieldMask(curStep.width, curStep.start);
    seqWr.value = 16'(curStep.data) << curStep.start;
  end

  assign busWrite  = awHeld_r && wHeld_r && !bValid_r;
  assign timerLoad = (state_r == power_seq_pkg::SEQ_WRITE);

  // Bus write capture, response and register updates
  always_comb begin
    awHeld_nxt    = awHeld_r;
    wHeld_nxt     = wHeld_r;
    awAddr_nxt    = awAddr_r;
    wData_nxt     = wData_r;
    wStrb_nxt     = wStrb_r;
    bValid_nxt    = bValid_r;
    bResp_nxt     = bResp_r;
    pair1Line_nxt = pair1Line_r;
    pair2Line_nxt = pair2Line_r;
    popCtrl2_nxt  = popCtrl2_r;
    launch_nxt    = launch_r;
    pwrMgmt1_nxt  = pwrMgmt1_r;
    servoCtl_nxt  = servoCtl_r;
    cpumpCtl_nxt  = cpumpCtl_r;
    hpAnalog_nxt  = hpAnalog_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    // Sequencer writes first so a bus write in the same cycle wins
    if (seqWr.valid) begin
      case (seqWr.addr)
        `IDX_PWR_MGMT1:
          pwrMgmt1_nxt = merge(pwrMgmt1_r, seqWr.mask, seqWr.value);
        `IDX_SERVO_CTRL:
          servoCtl_nxt = merge(servoCtl_r, seqWr.mask, seqWr.value);
        `IDX_CPUMP_CTRL:
          cpumpCtl_nxt = merge(cpumpCtl_r, seqWr.mask, seqWr.value);
        `IDX_HP_ANALOGUE:
          hpAnalog_nxt = merge(hpAnalog_r, seqWr.mask, seqWr.value);
        default: ; // see [R15]
      endcase
    end
    if (busWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = RESP_OKAY;
      case (awAddr_r[9:2])
        `IDX_PAIR1_LINE: pair1Line_nxt = laneWrite(pair1Line_r, wData_r,
                                                   wStrb_r);
        `IDX_PAIR2_LINE: pair2Line_nxt = laneWrite(pair2Line_r, wData_r,
                                                   wStrb_r);
        `IDX_POP_CTRL2:  popCtrl2_nxt = laneWrite(popCtrl2_r, wData_r,
                                                  wStrb_r);
        `IDX_SEQ_LAUNCH: launch_nxt = laneWrite(launch_r, wData_r, wStrb_r);
        `IDX_PWR_MGMT1:  pwrMgmt1_nxt = laneWrite(pwrMgmt1_r, wData_r,
                                                  wStrb_r);
        `IDX_SERVO_CTRL: servoCtl_nxt = laneWrite(servoCtl_r, wData_r,
                                                  wStrb_r);
        `IDX_CPUMP_CTRL: cpumpCtl_nxt = laneWrite(cpumpCtl_r, wData_r,
                                                  wStrb_r);
        `IDX_HP_ANALOGUE: hpAnalog_nxt = laneWrite(hpAnalog_r, wData_r,
                                                   wStrb_r);
        `IDX_SEQ_STATUS: bResp_nxt = RESP_OKAY; // Read-only, write ignored
        default:         bResp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // Launch decode, stepping and end of program
  always_comb begin
    state_nxt = state_r;
    index_nxt = index_r;
    case (state_r)
      power_seq_pkg::SEQ_IDLE: begin
        if (busWrite && awAddr_r[9:2] == `IDX_SEQ_LAUNCH &&
            wStrb_r[1:0] == 2'b11) begin
          if (wData_r[15:0] == `LAUNCH_STARTUP) begin
            index_nxt = `STARTUP_INDEX; // see [R1]
            state_nxt = power_seq_pkg::SEQ_WRITE;
          end else if (wData_r[15:0] == `LAUNCH_SHUTDOWN) begin
            index_nxt = `SHUTDOWN_INDEX; // see [R6]
            state_nxt = power_seq_pkg::SEQ_WRITE;
          end
        end
      end
      power_seq_pkg::SEQ_WRITE: state_nxt = power_seq_pkg::SEQ_WAIT;
      power_seq_pkg::SEQ_WAIT: begin
        if (timerDone) begin
          if (curStep.eos) begin
            state_nxt = power_seq_pkg::SEQ_IDLE; // see [R14]
          end else begin
            index_nxt = index_r + 5'h01;
            state_nxt = power_seq_pkg::SEQ_WRITE;
          end
        end
      end
      default: state_nxt = power_seq_pkg::SEQ_IDLE;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_comb begin
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (s_axi_rvalid && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = RESP_OKAY;
      rData_nxt  = 32'h0000_0000;
      case (s_axi_araddr[9:2])
        `IDX_PAIR1_LINE:  rData_nxt[15:0] = pair1Line_r;
        `IDX_PAIR2_LINE:  rData_nxt[15:0] = pair2Line_r;
        `IDX_POP_CTRL2:   rData_nxt[15:0] = popCtrl2_r;
        `IDX_SEQ_LAUNCH:  rData_nxt[15:0] = launch_r;
        `IDX_PWR_MGMT1:   rData_nxt[15:0] = pwrMgmt1_r;
        `IDX_SERVO_CTRL:  rData_nxt[15:0] = servoCtl_r;
        `IDX_CPUMP_CTRL:  rData_nxt[15:0] = cpumpCtl_r;
        `IDX_HP_ANALOGUE: rData_nxt[15:0] = hpAnalog_r;
        `IDX_SEQ_STATUS:  rData_nxt[5:0] = {busyOut_r, index_r};
        default:          rResp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // Ready only while the matching holding slot is empty
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready  = !wHeld_r && !bValid_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // Analogue control bits straight from register flops
  assign charge_pump_enable                 = cpumpCtl_r[15];
  assign hp_left_input_stage_enable         = pwrMgmt1_r[9];
  assign hp_right_input_stage_enable        = pwrMgmt1_r[8];
  assign speaker_output_enable              = pwrMgmt1_r[12];
  assign hp_left_short_removal              = hpAnalog_r[7];
  assign hp_left_output_stage_enable        = hpAnalog_r[6];
  assign hp_left_intermediate_stage_enable  = hpAnalog_r[5];
  assign hp_right_short_removal             = hpAnalog_r[3];
  assign hp_right_output_stage_enable       = hpAnalog_r[2];
  assign hp_right_intermediate_stage_enable = hpAnalog_r[1];
  assign servo_channel_enable               = servoCtl_r[1:0];
  assign servo_startup_trigger              = servoCtl_r[5:4];
  assign seq_busy                           = busyOut_r;
  assign midrail_reference_buffer_on        = midBuf_r;
  assign pair1_clamp_connect                = clamp1_r;
  assign pair2_clamp_connect                = clamp2_r;

  // Registering; clamp levels use the disabled-stage condition
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pair1Line_r <= `PAIR_LINE_RESET; // see [R11]
      pair2Line_r <= `PAIR_LINE_RESET; // see [R11]
      popCtrl2_r  <= `POP_CTRL2_RESET; // see [R10]
      launch_r    <= 16'h0000;
      pwrMgmt1_r  <= 16'h0000;
      servoCtl_r  <= 16'h0000;
      cpumpCtl_r  <= 16'h0000;
      hpAnalog_r  <= 16'h0000;
      awHeld_r    <= 1'b0;
      wHeld_r     <= 1'b0;
      awAddr_r    <= 10'h000;
      wData_r     <= 32'h0000_0000;
      wStrb_r     <= 4'h0;
      bValid_r    <= 1'b0;
      bResp_r     <= 2'b00;
      rValid_r    <= 1'b0;
      rData_r     <= 32'h0000_0000;
      rResp_r     <= 2'b00;
      state_r     <= power_seq_pkg::SEQ_IDLE;
      index_r     <= 5'h00;
      busyOut_r   <= 1'b0;
      midBuf_r    <= 1'b0;
      clamp1_r    <= 1'b0;
      clamp2_r    <= 1'b0;
    end else begin
      pair1Line_r <= pair1Line_nxt;
      pair2Line_r <= pair2Line_nxt;
      popCtrl2_r  <= popCtrl2_nxt;
      launch_r    <= launch_nxt;
      pwrMgmt1_r  <= pwrMgmt1_nxt;
      servoCtl_r  <= servoCtl_nxt;
      cpumpCtl_r  <= cpumpCtl_nxt;
      hpAnalog_r  <= hpAnalog_nxt;
      awHeld_r    <= awHeld_nxt;
      wHeld_r     <= wHeld_nxt;
      awAddr_r    <= awAddr_nxt;
      wData_r     <= wData_nxt;
      wStrb_r     <= wStrb_nxt;
      bValid_r    <= bValid_nxt;
      bResp_r     <= bResp_nxt;
      rValid_r    <= rValid_nxt;
      rData_r     <= rData_nxt;
      rResp_r     <= rResp_nxt;
      state_r     <= state_nxt;
      index_r     <= index_nxt;
      busyOut_r   <= (state_nxt != power_seq_pkg::SEQ_IDLE);
      midBuf_r    <= popCtrl2_nxt[`MIDBUF_BIT]; // see [R10]
      // Pair one feeds left input stage, pair two the right one
      clamp1_r    <= pair1Line_nxt[`CLAMP_BIT] &&
                     !pwrMgmt1_nxt[9]; // see [R9]
      clamp2_r    <= pair2Line_nxt[`CLAMP_BIT] &&
                     !pwrMgmt1_nxt[8]; // see [R9]
    end
  end

endmodule

// ---- power_seq_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef POWER_SEQ_MAP_SVH
`define POWER_SEQ_MAP_SVH

// Printed offsets are register indexes; byte address is four times these
`define IDX_PAIR1_LINE     8'h16
`define IDX_PAIR2_LINE     8'h17
`define IDX_POP_CTRL2      8'h39
`define IDX_SEQ_LAUNCH     8'h49
// Target control registers written by the sequencer
`define IDX_PWR_MGMT1      8'h01
`define IDX_SERVO_CTRL     8'h54
`define IDX_CPUMP_CTRL     8'h4C
`define IDX_HP_ANALOGUE    8'h60
`define IDX_DUMMY          8'hFF
// Status register of our own
`define IDX_SEQ_STATUS     8'h80

`define LAUNCH_STARTUP     16'h0100
`define LAUNCH_SHUTDOWN    16'h0110
`define STARTUP_INDEX      5'h00
`define SHUTDOWN_INDEX     5'h10

`define CLAMP_BIT          0
`define MIDBUF_BIT         3
`define PAIR_LINE_RESET    16'h0001
`define POP_CTRL2_RESET    16'h0000

// Step time unit 62.5 us, in ns, and the clock period in ns
`define STEP_UNIT_NS       62500
`define CLK_PERIOD_NS      25
`define STEP_UNIT_CYC      (`STEP_UNIT_NS / `CLK_PERIOD_NS)
`define STEP_OVERHEAD      8

`endif

// ---- power_seq_pkg.sv ----
// Types shared by the sequencer files
package power_seq_pkg;

  // One program step
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] start;
    logic [2:0] width;
    logic [7:0] data;
    logic [3:0] delay;
    logic       eos;
  } step_t;

  // One register write into the control file
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] mask;
    logic [15:0] value;
  } ctl_write_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_WRITE = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_state_t;

endpackage

// ---- step_rom.sv ----
// Default sequencer programs, start-up and shut-down
`timescale 1ns/1ps
`include "power_seq_map.svh"

module step_rom (
  // Lookup
  input  wire logic [4:0]          index,
  output power_seq_pkg::step_t     step
);

  // Fixed table, unused indexes are end-flagged dummy writes
  always_comb begin
    step = '{`IDX_DUMMY, 4'h0, 3'h0, 8'h00, 4'h0, 1'b1};
    case (index)
      5'h00: step = '{`IDX_CPUMP_CTRL, 4'hF, 3'h0, 8'h01, 4'h6, 1'b0}; // see [R2]
      5'h01: step = '{`IDX_PWR_MGMT1, 4'h7, 3'h2, 8'h07, 4'h0, 1'b0}; // see [R2]
      5'h02: step = '{`IDX_HP_ANALOGUE, 4'h1, 3'h4, 8'h11, 4'h0, 1'b0}; // see [R3]
      5'h03: step = '{`IDX_SERVO_CTRL, 4'h0, 3'h6, 8'h33, 4'h9, 1'b0}; // see [R3]
      5'h04: step = '{`IDX_DUMMY, 4'h0, 3'h0, 8'h00, 4'h5, 1'b0}; // see [R4]
      5'h05: step = '{`IDX_DUMMY, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0}; // see [R4]
      5'h06: step = '{`IDX_DUMMY, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0}; // see [R4]
      5'h07: step = '{`IDX_HP_ANALOGUE, 4'h2, 3'h5, 8'h3B, 4'h0, 1'b1}; // see [R5]
      5'h10: step = '{`IDX_HP_ANALOGUE, 4'h1, 3'h6, 8'h00, 4'h0, 1'b0}; // see [R7]
      5'h11: step = '{`IDX_SERVO_CTRL, 4'h0, 3'h1, 8'h00, 4'h0, 1'b0}; // see [R7]
      5'h12: step = '{`IDX_PWR_MGMT1, 4'h8, 3'h1, 8'h00, 4'h0, 1'b0}; // see [R7]
      5'h13: step = '{`IDX_CPUMP_CTRL, 4'hF, 3'h0, 8'h00, 4'h0, 1'b0}; // see [R8]
      5'h14: step = '{`IDX_PWR_MGMT1, 4'hC, 3'h1, 8'h00, 4'h0, 1'b1}; // see [R8]
      default: ;
    endcase
  end

endmodule

// ---- step_timer.sv ----
// Per-step wait counter: unit * (2^code + 8) cycles
`timescale 1ns/1ps
`include "power_seq_map.svh"

module step_timer #(
  parameter int UNIT_CYC = `STEP_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        load,
  input  wire logic [3:0]  code,
  output logic             done
);

  logic [15:0] unitCnt_r, unitCnt_nxt;
  logic [15:0] units_r, units_nxt;
  logic        busy_r, busy_nxt;

  // Units for a code, used by the load path only
  function automatic logic [15:0] unitsFor(input logic [3:0] c);
    unitsFor = 16'((32'h1 << c) + `STEP_OVERHEAD);
  endfunction

  // Unit divider then unit countdown; done pulses on the last cycle
  always_comb begin
    unitCnt_nxt = unitCnt_r;
    units_nxt   = units_r;
    busy_nxt    = busy_r;
    done        = 1'b0;
    if (load) begin
      busy_nxt    = 1'b1;
      unitCnt_nxt = 16'(UNIT_CYC - 2); // Write cycle is in it, see [R12]
      units_nxt   = unitsFor(code); // see [R12]
    end else if (busy_r) begin
      if (unitCnt_r != 16'h0000) begin
        unitCnt_nxt = unitCnt_r - 16'h0001;
      end else if (units_r == 16'h0001) begin
        busy_nxt = 1'b0;
        done     = 1'b1;
      end else begin
        unitCnt_nxt = 16'(UNIT_CYC - 1);
        units_nxt   = units_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unitCnt_r <= 16'h0000;
      units_r   <= 16'h0000;
      busy_r    <= 1'b0;
    end else begin
      unitCnt_r <= unitCnt_nxt;
      units_r   <= units_nxt;
      busy_r    <= busy_nxt;
    end
  end

endmodule

// ---- power_seq_monitor.sv ----
// Port-level assertions for the default power sequencer
`timescale 1ns/1ps
module power_seq_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register bus handshakes
  input wire logic       s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Control levels
  input wire logic       charge_pump_enable,
  input wire logic       hp_left_input_stage_enable,
  input wire logic       hp_left_intermediate_stage_enable,
  input wire logic       hp_left_output_stage_enable,
  input wire logic [1:0] servo_channel_enable,
  input wire logic       speaker_output_enable,
  input wire logic       midrail_reference_buffer_on,
  input wire logic       pair1_clamp_connect,
  input wire logic       seq_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Responses hold until the master takes them
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  // No new request accepted while an answer is pending
  property p_awblock;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_awblock: assert property (p_awblock) else $error("aw taken early");
  property p_arblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblock: assert property (p_arblock) else $error("ar taken early");
  // Buffer changes only as a result of a bus write
  property p_midbuf;
    $changed(midrail_reference_buffer_on) |-> s_axi_bvalid;
  endproperty
  a_midbuf: assert property (p_midbuf) else $error("lone buffer");
  // Enabling the input stage releases the clamp next cycle
  property p_clamp;
    $rose(hp_left_input_stage_enable) |=> !pair1_clamp_connect;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp still on");
  // During a sequencer run, output stage only comes on after servo and intermediate stage
  property p_order;
    $rose(hp_left_output_stage_enable) && seq_busy |->
      servo_channel_enable == 2'b11 && hp_left_intermediate_stage_enable;
  endproperty
  a_order: assert property (p_order) else $error("early output");
  // A finished shut-down leaves left input stage, speaker and servo channels off
  property p_shutdown;
    $fell(seq_busy) && !charge_pump_enable |-> !hp_left_input_stage_enable
      && !speaker_output_enable && servo_channel_enable == 2'b00;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("left on");
endmodule

bind power_seq power_seq_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .charge_pump_enable(charge_pump_enable),
  .hp_left_input_stage_enable(hp_left_input_stage_enable),
  .hp_left_intermediate_stage_enable(hp_left_intermediate_stage_enable),
  .hp_left_output_stage_enable(hp_left_output_stage_enable),
  .servo_channel_enable(servo_channel_enable),
  .speaker_output_enable(speaker_output_enable),
  .midrail_reference_buffer_on(midrail_reference_buffer_on),
  .pair1_clamp_connect(pair1_clamp_connect), .seq_busy(seq_busy));

// ---- test_default_power_sequences.sv ----
// Self-checking bench for the default power sequencer
`timescale 1ns/1ps
module test_default_power_sequences;
  localparam int U = 2;
  logic        clk, sys_rst, busy, cpEn, hpLIn, hpRIn, hpROut, spkEn;
  logic        midBuf, clamp1, clamp2, hpLMid, hpRMid, hpLOut, hpLSht, hpRSht;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, servoTrig, servoEn, rdResp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          nMismatch = 0, samplesChecked = 0, cycles = 0, n;

  power_seq #(.UNIT_CYC(U)) DUT (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .charge_pump_enable(cpEn),
    .hp_left_input_stage_enable(hpLIn), .hp_right_input_stage_enable(hpRIn),
    .hp_left_intermediate_stage_enable(hpLMid),
    .hp_right_intermediate_stage_enable(hpRMid),
    .hp_left_output_stage_enable(hpLOut), .hp_left_short_removal(hpLSht),
    .hp_right_output_stage_enable(hpROut), .hp_right_short_removal(hpRSht),
    .servo_channel_enable(servoEn), .servo_startup_trigger(servoTrig),
    .speaker_output_enable(spkEn), .midrail_reference_buffer_on(midBuf),
    .pair1_clamp_connect(clamp1), .pair2_clamp_connect(clamp2),
    .seq_busy(busy));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic a, w, b;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    logic a, got;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge clk);
      a = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      rdData = s_axi_rdata;
      rdResp = s_axi_rresp;
      @(posedge clk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
    rd(idx);
    check("register", rdData, {16'h0000, exp});
    check("read response", {30'h0, rdResp}, 32'h0);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  // Launch, then follow the program until it stops by itself
  task automatic run_program(input logic [15:0] code);
    wr(8'h49, code);
    while (!busy) @(negedge clk);
    while (busy) @(negedge clk);
  endtask

  // Hang guard: the full run needs under two thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nMismatch++;
      complete_run();
    end
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle(2);
    check("pair1 clamp", clamp1, 1);
    check("pair2 clamp", clamp2, 1);
    check("buffer", midBuf, 0);
    rdchk(8'h16, 16'h0001);
    rdchk(8'h17, 16'h0001);
    rdchk(8'h39, 16'h0000);
    rd(8'h20);
    check("unmapped data", rdData, 0);
    check("unmapped resp", {30'h0, rdResp}, 2);
    $display("end of test reset");
    wr(8'h39, 16'h0008);
    settle(2);
    check("buffer on", midBuf, 1);
    wr(8'h39, 16'h0000);
    settle(2);
    check("buffer off", midBuf, 0);
    wr(8'h16, 16'h0000);
    settle(2);
    check("pair1 unclamped", clamp1, 0);
    wr(8'h16, 16'h0001);
    settle(2);
    check("pair1 clamped", clamp1, 1);
    $display("end of test clamps");
    wr(8'h49, 16'h0101);
    settle(3);
    check("wrong launch", busy, 0);
    wr(8'h60, 16'h0001);
    wr(8'h01, 16'h1000);
    wr(8'h49, 16'h0100);
    do @(negedge clk); while (!cpEn);
    n = 0;
    while (!hpLIn) begin
      @(negedge clk);
      n++;
    end
    check("step time", n, U * (2 ** 6 + 8));
    check("busy", busy, 1);
    while (busy) @(negedge clk) n++;
    check("program time", n, U * (72 + 5 * 9 + 520 + 40) - 1);
    settle(1);
    check("stopped", busy, 0);
    rdchk(8'h4C, 16'h8000);
    rdchk(8'h01, 16'h1380);
    rdchk(8'h60, 16'h00EF);
    rdchk(8'h54, 16'h0033);
    check("outputs", {hpRIn, hpROut, servoTrig, hpLMid, hpRMid, hpLOut,
                      hpLSht, hpRSht}, 9'h1FF);
    check("clamps released", {clamp1, clamp2}, 0);
    $display("end of test start-up");
    run_program(16'h0110);
    rdchk(8'h60, 16'h0001);
    rdchk(8'h54, 16'h0030);
    rdchk(8'h01, 16'h0080);
    rdchk(8'h4C, 16'h0000);
    check("off", {spkEn, hpLMid, hpLOut, hpLSht, hpRSht}, 0);
    check("clamps back", {clamp1, clamp2}, 3);
    $display("end of test shut-down");
    complete_run();
  end
endmodule
